// >>> cdu_host_model.sv
/*
 * cdu_host_model: host side of the transfer port, as seen after the front-end.
 * Assumes the unit registers read answers on the taking edge itself.
 */
`timescale 1ns/1ps
module cdu_host_model
    import cdu_pkg::*;
(
    // clock
    input  wire logic         core_clk,
    // transfers toward the unit
    output logic              xfer_stb,
    output cdu_pkg::cdu_xfer_s xfer,
    // read answers
    input  wire logic [7:0]   rd_byte_r,
    input  wire logic         rd_valid_r
);
    initial
    begin
        xfer_stb = 1'b0;
        xfer     = '0;
    end

    // no busy polling: transfers may follow every cycle
    task automatic put(input logic sel, input logic rnw, input logic [7:0] d);
        @(posedge core_clk);
        xfer_stb <= 1'b1;
        xfer     <= '{cmd_data_select: sel, rnw: rnw, parallel_bus: d};
    endtask

    // released lines flip so a stale byte is never taken for a fresh one
    task automatic idle();
        @(posedge core_clk);
        xfer_stb              <= 1'b0;
        xfer.parallel_bus     <= ~xfer.parallel_bus;
    endtask

    // 4-bit bus: high nibble first, both on the upper lines
    task automatic put_nib(input logic sel, input logic rnw, input logic [7:0] d);
        put(sel, rnw, {d[7:4], 4'h0});
        put(sel, rnw, {d[3:0], 4'h0});
    endtask

    // callers need not load an address before data reads; answer sampled in its cycle
    task automatic read(input logic sel, output logic [7:0] rb, output logic v);
        put(sel, 1'b1, 8'h00);
        idle();
        #1;
        rb = rd_byte_r;
        v  = rd_valid_r;
    endtask
endmodule

// >>> cdu_instr_unit.sv
/*
 * cdu_instr_unit: instruction decoder and state keeper of a two-line
 * character display. Takes decoded host transfers, keeps the address
 * counter, both RAMs and the display settings, and answers reads.
 * Assumes a port front-end on core_clk delivering one-cycle transfer strobes,
 * and a software port with one-cycle strobes that never overlap.
 */
`timescale 1ns/1ps
module cdu_instr_unit #(
    parameter int DD_DEPTH = cdu_pkg::CDU_DD_DEPTH,
    parameter int CG_DEPTH = cdu_pkg::CDU_CG_DEPTH
) (
    // clock, reset, enable
    input  wire logic                          core_clk,
    input  wire logic                          rst,
    input  wire logic                          clk_en,
    // host transfers from the port front-end
    input  wire logic                          xfer_stb,
    input  wire cdu_pkg::cdu_xfer_s            xfer,
    output logic [7:0]                         rd_byte_r,
    output logic                               rd_valid_r,
    // software register port
    input  wire logic [cdu_pkg::CDU_RA_W-1:0]  reg_addr,
    input  wire logic [31:0]                   reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic [31:0]                        reg_rdata_r,
    // display state
    output cdu_pkg::cdu_disp_s                 disp_r,
    output logic [6:0]                         luma_pct_r,
    output logic [1:0]                         port_mode_r,
    output logic                               nibble_mode_r
);
    import cdu_pkg::*;

    // storage cannot exceed what the counter can address
    if (DD_DEPTH < 1 || DD_DEPTH > (1 << CDU_AC_W))
    begin : g_bad_dd
        $error("DD_DEPTH out of range");
    end
    if (CG_DEPTH < 1 || CG_DEPTH > (1 << CDU_CG_AW))
    begin : g_bad_cg
        $error("CG_DEPTH out of range");
    end

    logic [7:0]          dd_mem [DD_DEPTH];
    logic [7:0]          cg_mem [CG_DEPTH];
    logic                nib_ph_r;
    logic [3:0]          nib_hi_r;
    logic [3:0]          rd_lo_r;
    logic                nibble_mode;
    logic [7:0]          wr_byte;
    logic                wr_exec;
    logic                rd_exec;
    logic                data_wr;
    logic                data_rd;
    logic                cmd_wr;
    cdu_op_e             op;
    logic [CDU_AC_W-1:0] ac;
    logic [CDU_AC_W-1:0] ac_step;
    logic [7:0]          ram_byte;
    logic                dd_hit;
    logic                cg_hit;
    logic                clear_all;

    assign ac = disp_r.cursor_addr_counter;

    // serial transfers are always whole bytes, bus width applies to parallel only
    assign nibble_mode = !disp_r.bus_width_sel && (port_mode_r != CDU_PORT_SERIAL);

    // writes act on the low half, reads on the high half so the byte is fixed early
    assign wr_byte = nibble_mode ? {nib_hi_r, xfer.parallel_bus[7:4]}
                                 : xfer.parallel_bus;
    assign wr_exec = clk_en && xfer_stb && !xfer.rnw && (!nibble_mode || nib_ph_r);
    assign rd_exec = clk_en && xfer_stb && xfer.rnw && (!nibble_mode || !nib_ph_r);
    assign data_wr = wr_exec && xfer.cmd_data_select;
    assign data_rd = rd_exec && xfer.cmd_data_select;
    assign cmd_wr  = wr_exec && !xfer.cmd_data_select;

    // leading-one decode of instruction bytes, highest bit first
    always_comb
    begin
        op = CDU_OP_NONE;
        if (wr_byte[CDU_LEAD_DD])
            op = CDU_OP_DD;
        else if (wr_byte[CDU_LEAD_CG])
            op = CDU_OP_CG;
        else if (wr_byte[CDU_LEAD_FUNC])
            op = CDU_OP_FUNC;
        else if (wr_byte[CDU_LEAD_SHIFT])
            op = CDU_OP_SHIFT;
        else if (wr_byte[CDU_LEAD_DISP])
            op = CDU_OP_DISP;
        else if (wr_byte[CDU_LEAD_ENTRY])
            op = CDU_OP_ENTRY;
        else if (wr_byte[CDU_LEAD_HOME])
            op = CDU_OP_HOME;
        else if (wr_byte[CDU_LEAD_CLEAR])
            op = CDU_OP_CLEAR;
    end

    assign clear_all = cmd_wr && (op == CDU_OP_CLEAR);

    // counter step follows the direction bit; wraps at the counter width
    assign ac_step = disp_r.incr ? ac + 7'h01 : ac - 7'h01;

    // out-of-range addresses neither store nor read back data
    assign dd_hit = !disp_r.glyph_sel && (int'(ac) < DD_DEPTH);
    assign cg_hit = disp_r.glyph_sel && (int'(ac[CDU_CG_AW-1:0]) < CG_DEPTH);

    // byte at the counter, from whichever RAM was selected last
    always_comb
    begin
        ram_byte = 8'h00;
        if (dd_hit)
            ram_byte = dd_mem[ac];
        else if (cg_hit)
            ram_byte = cg_mem[ac[CDU_CG_AW-1:0]];
    end

    // character and pattern RAMs, one flip-flop byte per entry
    genvar gi;
    generate
        for (gi = 0; gi < DD_DEPTH; gi++)
        begin : g_dd
            always_ff @(posedge core_clk)
            begin
                if (rst)
                    dd_mem[gi] <= CDU_SPACE_CODE;
                else if (clear_all)
                    dd_mem[gi] <= CDU_SPACE_CODE;
                else if (data_wr && dd_hit && ac == CDU_AC_W'(gi))
                    dd_mem[gi] <= wr_byte;
            end
        end
        for (gi = 0; gi < CG_DEPTH; gi++)
        begin : g_cg
            always_ff @(posedge core_clk)
            begin
                if (rst)
                    cg_mem[gi] <= CDU_CG_RESET;
                else if (data_wr && cg_hit && ac[CDU_CG_AW-1:0] == CDU_CG_AW'(gi))
                    cg_mem[gi] <= wr_byte;
            end
        end
    endgenerate

    // nibble phase; a full byte in 8-bit mode never leaves phase zero
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            nib_ph_r <= 1'b0;
            nib_hi_r <= 4'h0;
        end
        else if (clk_en && xfer_stb)
        begin
            if (nibble_mode)
            begin
                nib_ph_r <= !nib_ph_r;
                nib_hi_r <= xfer.parallel_bus[7:4];
            end
            else
                nib_ph_r <= 1'b0;
        end
    end

    // address counter, RAM select and display shift
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            disp_r.cursor_addr_counter <= CDU_AC_RESET;
            disp_r.glyph_sel           <= 1'b0;
            disp_r.shift_ofs           <= '0;
        end
        else if (data_wr)
        begin
            disp_r.cursor_addr_counter <= ac_step;
            if (disp_r.shift_en && !disp_r.glyph_sel)
                disp_r.shift_ofs <= disp_r.incr ? disp_r.shift_ofs + 7'h01
                                                : disp_r.shift_ofs - 7'h01;
        end
        else if (data_rd)
            disp_r.cursor_addr_counter <= ac_step;
        else if (cmd_wr)
        begin
            case (op)
                CDU_OP_DD:
                begin
                    disp_r.cursor_addr_counter <= wr_byte[CDU_AC_W-1:0];
                    disp_r.glyph_sel           <= 1'b0;
                end
                CDU_OP_CG:
                begin
                    disp_r.cursor_addr_counter <=
                        {1'b0, wr_byte[CDU_CG_AW-1:0]};
                    disp_r.glyph_sel           <= 1'b1;
                end
                CDU_OP_CLEAR, CDU_OP_HOME:
                begin
                    disp_r.cursor_addr_counter <= CDU_AC_RESET;
                    disp_r.glyph_sel           <= 1'b0;
                    disp_r.shift_ofs           <= '0;
                end
                CDU_OP_SHIFT:
                begin
                    // moves the cursor without touching RAM; lands back in characters
                    disp_r.glyph_sel <= 1'b0;
                    disp_r.cursor_addr_counter <= wr_byte[CDU_SH_RIGHT] ? ac + 7'h01
                                                                        : ac - 7'h01;
                    if (wr_byte[CDU_SH_DISP])
                        disp_r.shift_ofs <= wr_byte[CDU_SH_RIGHT] ? disp_r.shift_ofs - 7'h01
                                                                  : disp_r.shift_ofs + 7'h01;
                end
                default:
                    disp_r.cursor_addr_counter <= ac;
            endcase
        end
    end

    // entry mode; clear also restores increment
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            disp_r.incr     <= 1'b1;
            disp_r.shift_en <= 1'b0;
        end
        else if (cmd_wr && op == CDU_OP_ENTRY)
        begin
            disp_r.incr     <= wr_byte[CDU_EM_INCR];
            disp_r.shift_en <= wr_byte[CDU_EM_SHIFT];
        end
        else if (clear_all)
            disp_r.incr <= 1'b1;
    end

    // display on/off control
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            disp_r.disp_on   <= 1'b0;
            disp_r.cursor_on <= 1'b0;
            disp_r.blink_on  <= 1'b0;
        end
        else if (cmd_wr && op == CDU_OP_DISP)
        begin
            disp_r.disp_on   <= wr_byte[CDU_DC_DISP];
            disp_r.cursor_on <= wr_byte[CDU_DC_CURSOR];
            disp_r.blink_on  <= wr_byte[CDU_DC_BLINK];
        end
    end

    // function set: bus width, lines, luminance; RAMs and counter untouched
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            disp_r.bus_width_sel <= 1'b1;
            disp_r.two_lines     <= 1'b1;
            disp_r.luma_sel_hi   <= 1'b0;
            disp_r.luma_sel_lo   <= 1'b0;
        end
        else if (cmd_wr && op == CDU_OP_FUNC)
        begin
            disp_r.bus_width_sel <= wr_byte[CDU_FS_WIDTH];
            disp_r.two_lines     <= wr_byte[CDU_FS_LINES];
            disp_r.luma_sel_hi   <= wr_byte[CDU_FS_LUMA_HI];
            disp_r.luma_sel_lo   <= wr_byte[CDU_FS_LUMA_LO];
        end
    end

    // luminance percentage follows the selected code
    always_ff @(posedge core_clk)
    begin
        if (rst)
            luma_pct_r <= CDU_LUMA_100;
        else if (clk_en)
        begin
            case ({disp_r.luma_sel_hi, disp_r.luma_sel_lo})
                2'h0:    luma_pct_r <= CDU_LUMA_100;
                2'h1:    luma_pct_r <= CDU_LUMA_75;
                2'h2:    luma_pct_r <= CDU_LUMA_50;
                default: luma_pct_r <= CDU_LUMA_25;
            endcase
        end
    end

    // reads answer the cycle after the strobe; nothing executes a busy wait
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            rd_byte_r  <= 8'h00;
            rd_valid_r <= 1'b0;
            rd_lo_r    <= 4'h0;
        end
        else if (clk_en)
        begin
            rd_valid_r <= xfer_stb && xfer.rnw;
            if (rd_exec)
            begin
                // counter read is pure: disp_r and the counter do not move; rd_lo_r still loads
                if (xfer.cmd_data_select)
                begin
                    rd_byte_r <= ram_byte;
                    rd_lo_r   <= ram_byte[3:0];
                end
                else
                begin
                    rd_byte_r <= {CDU_BUSY_VALUE, ac};
                    rd_lo_r   <= ac[3:0];
                end
            end
            else if (xfer_stb && xfer.rnw)
                rd_byte_r <= {rd_lo_r, 4'h0};
        end
    end

    // port mode register and nibble-mode mirror; m68 after reset
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            port_mode_r   <= CDU_PORT_M68;
            nibble_mode_r <= 1'b0;
        end
        else if (clk_en)
        begin
            nibble_mode_r <= nibble_mode;
            if (reg_wr && reg_addr == CDU_REG_CFG && reg_wdata[1:0] != 2'h3)
                port_mode_r <= reg_wdata[1:0];
        end
    end

    // software read-back; unmapped offsets read zero
    always_ff @(posedge core_clk)
    begin
        if (rst)
            reg_rdata_r <= 32'h0000_0000;
        else if (clk_en && reg_rd)
        begin
            case (reg_addr)
                CDU_REG_CFG:  reg_rdata_r <= {29'h0, nib_ph_r, port_mode_r};
                CDU_REG_STAT: reg_rdata_r <= {8'h00, disp_r};
                default:      reg_rdata_r <= 32'h0000_0000;
            endcase
        end
    end

endmodule

// >>> cdu_instr_unit_checker.sv
/*
 * cdu_instr_unit_checker: concurrent checks on the ports of cdu_instr_unit.
 * Assumes one clock domain and a bind from the testbench top file.
 */
`timescale 1ns/1ps
module cdu_instr_unit_checker
    import cdu_pkg::*;
#(
    parameter int DD_DEPTH = CDU_DD_DEPTH,
    parameter int CG_DEPTH = CDU_CG_DEPTH
) (
    // clock and reset
    input wire logic                         core_clk,
    input wire logic                         rst,
    input wire logic                         clk_en,
    // host transfers
    input wire logic                         xfer_stb,
    input wire cdu_pkg::cdu_xfer_s           xfer,
    input wire logic [7:0]                   rd_byte_r,
    input wire logic                         rd_valid_r,
    // register port
    input wire logic [cdu_pkg::CDU_RA_W-1:0] reg_addr,
    input wire logic [31:0]                  reg_wdata,
    input wire logic                         reg_wr,
    // display state
    input wire cdu_pkg::cdu_disp_s           disp_r,
    input wire logic [6:0]                   luma_pct_r,
    input wire logic [1:0]                   port_mode_r
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // whole-byte transfers only; nibble pairs are judged by the testbench
    logic       take;
    logic [6:0] step;
    logic [7:0] b;
    assign take = xfer_stb && clk_en && disp_r.bus_width_sel;
    assign step = disp_r.incr ? 7'h01 : 7'h7f;
    assign b    = xfer.parallel_bus;

    function automatic logic [6:0] luma_of(input logic [1:0] c);
        return (c == 2'h0) ? CDU_LUMA_100 : (c == 2'h1) ? CDU_LUMA_75 :
               (c == 2'h2) ? CDU_LUMA_50 : CDU_LUMA_25;
    endfunction

    sequence s_ac_read;  take && !xfer.cmd_data_select && xfer.rnw;  endsequence
    sequence s_func;     take && !xfer.cmd_data_select && !xfer.rnw && b[7:5] == 3'h1; endsequence
    sequence s_cg_load;  take && !xfer.cmd_data_select && !xfer.rnw && b[7:6] == 2'h1; endsequence
    sequence s_dd_load;  take && !xfer.cmd_data_select && !xfer.rnw && b[7];  endsequence
    sequence s_data_wr;  take && xfer.cmd_data_select && !xfer.rnw;  endsequence
    sequence s_data_rd;  take && xfer.cmd_data_select && xfer.rnw;  endsequence

    a_ac_read_busy: assert property (s_ac_read |=> rd_valid_r && $stable(disp_r) &&
        rd_byte_r == {CDU_BUSY_VALUE, $past(disp_r.cursor_addr_counter)})
        else $error("counter read answer wrong");
    a_read_answer_cause: assert property (rd_valid_r |-> $past(xfer_stb) && $past(xfer.rnw))
        else $error("read answer without a read");
    a_func_fields: assert property (s_func |=>
        disp_r.bus_width_sel == $past(b[CDU_FS_WIDTH]) && disp_r.two_lines == $past(b[CDU_FS_LINES])
        && {disp_r.luma_sel_hi, disp_r.luma_sel_lo} == $past(b[1:0])
        && $stable(disp_r.cursor_addr_counter) && $stable(disp_r.glyph_sel))
        else $error("function set fields wrong");
    a_luma_decode: assert property ($past(clk_en) |->
        luma_pct_r == luma_of({$past(disp_r.luma_sel_hi), $past(disp_r.luma_sel_lo)}))
        else $error("luminance percent wrong");
    a_cg_addr_load: assert property (s_cg_load |=> disp_r.glyph_sel &&
        disp_r.cursor_addr_counter == {1'b0, $past(b[5:0])})
        else $error("pattern address load wrong");
    a_dd_addr_load: assert property (s_dd_load |=> !disp_r.glyph_sel &&
        disp_r.cursor_addr_counter == $past(b[6:0]))
        else $error("character address load wrong");
    a_write_step: assert property (s_data_wr |=>
        disp_r.cursor_addr_counter[5:0] == $past(disp_r.cursor_addr_counter[5:0]) + $past(step[5:0])
        && disp_r.shift_ofs == $past(disp_r.shift_ofs)
           + (($past(disp_r.shift_en) && !$past(disp_r.glyph_sel)) ? $past(step) : 7'h00))
        else $error("write step or shift wrong");
    a_read_step: assert property (s_data_rd |=> rd_valid_r && $stable(disp_r.shift_ofs) &&
        disp_r.cursor_addr_counter[5:0] == $past(disp_r.cursor_addr_counter[5:0]) + $past(step[5:0]))
        else $error("read step wrong");
    a_mode_write: assert property (reg_wr && clk_en && reg_addr == CDU_REG_CFG &&
        reg_wdata[1:0] != 2'h3 |=> port_mode_r == $past(reg_wdata[1:0]))
        else $error("port mode write wrong");
endmodule

// >>> cdu_instr_unit_tb.sv
/*
 * cdu_instr_unit_tb: self-checking bench for cdu_instr_unit.
 * Assumes the host model and checker files are compiled before this one.
 */
`timescale 1ns/1ps
module cdu_instr_unit_tb;
    import cdu_pkg::*;
    logic                core_clk;
    logic                rst       = 1'b1;
    logic                clk_en    = 1'b1;
    logic                xfer_stb;
    cdu_xfer_s           xfer;
    logic [7:0]          rd_byte_r;
    logic                rd_valid_r;
    logic [CDU_RA_W-1:0] reg_addr  = '0;
    logic [31:0]         reg_wdata = '0;
    logic                reg_wr    = 1'b0;
    logic                reg_rd    = 1'b0;
    logic [31:0]         reg_rdata_r;
    cdu_disp_s           disp_r;
    logic [6:0]          luma_pct_r;
    logic [1:0]          port_mode_r;
    logic                nibble_mode_r;
    int                  n_mismatch = 0;
    int                  num_checks = 0;

    cdu_instr_unit dut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .xfer_stb(xfer_stb),
        .xfer(xfer), .rd_byte_r(rd_byte_r), .rd_valid_r(rd_valid_r), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
        .disp_r(disp_r), .luma_pct_r(luma_pct_r), .port_mode_r(port_mode_r),
        .nibble_mode_r(nibble_mode_r));
    cdu_host_model host (.core_clk(core_clk), .xfer_stb(xfer_stb), .xfer(xfer),
        .rd_byte_r(rd_byte_r), .rd_valid_r(rd_valid_r));

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic settle();
        host.idle();
        #1;
    endtask

    task automatic ld_dd(input logic [6:0] a);
        host.put(1'b0, 1'b0, {1'b1, a});
    endtask

    task automatic rd_chk(input logic sel, input logic [7:0] exp);
        logic [7:0] b;
        logic       v;
        host.read(sel, b, v);
        chk(v, 1'b1);
        chk(b, exp);
    endtask

    task automatic reg_acc(input logic wr, input logic [3:0] a, input logic [31:0] d,
                           output logic [31:0] q);
        @(posedge core_clk);
        reg_wr    <= wr;
        reg_rd    <= ~wr;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b0;
        #1;
        q = reg_rdata_r;
    endtask

    task automatic t_reset();
        cdu_disp_s e;
        e = '0;
        e.two_lines     = 1'b1;
        e.bus_width_sel = 1'b1;
        e.incr          = 1'b1;
        chk(disp_r, e);
        chk(luma_pct_r, CDU_LUMA_100);
        chk(port_mode_r, CDU_PORT_M68);
        rd_chk(1'b1, CDU_SPACE_CODE);
        rd_chk(1'b1, CDU_SPACE_CODE);
        ld_dd(7'h7f);
        rd_chk(1'b1, CDU_SPACE_CODE);
    endtask

    // every luminance code, line count toggled, counter left alone
    task automatic t_func();
        logic [6:0] lut [4] = '{CDU_LUMA_100, CDU_LUMA_75, CDU_LUMA_50, CDU_LUMA_25};
        ld_dd(7'h15);
        for (int i = 0; i < 4; i++)
        begin
            host.put(1'b0, 1'b0, {4'h3, i[0], 1'b0, i[1:0]});
            settle();
            chk({disp_r.bus_width_sel, disp_r.two_lines, disp_r.luma_sel_hi,
                 disp_r.luma_sel_lo}, {1'b1, i[0], i[1:0]});
            chk(disp_r.cursor_addr_counter, 7'h15);
            @(posedge core_clk);
            #1;
            chk(luma_pct_r, lut[i]);
        end
    endtask

    task automatic t_nibble();
        ld_dd(7'h40);
        host.put(1'b0, 1'b0, 8'h28);
        settle();
        chk(disp_r.bus_width_sel, 1'b0);
        @(posedge core_clk);
        #1;
        chk(nibble_mode_r, 1'b1);
        host.put_nib(1'b1, 1'b0, 8'h5a);
        host.put_nib(1'b0, 1'b0, 8'h38);
        settle();
        @(posedge core_clk);
        #1;
        chk({disp_r.bus_width_sel, nibble_mode_r}, 2'h2);
        chk(disp_r.cursor_addr_counter, 7'h41);
        ld_dd(7'h40);
        rd_chk(1'b1, 8'h5a);
    endtask

    task automatic t_ram();
        ld_dd(7'h10);
        for (int i = 1; i < 4; i++)
            host.put(1'b1, 1'b0, 8'(i * 8'h11));
        rd_chk(1'b0, 8'h13);
        ld_dd(7'h10);
        for (int i = 1; i < 4; i++)
            rd_chk(1'b1, 8'(i * 8'h11));
        host.put(1'b0, 1'b0, 8'h45);
        host.put(1'b1, 1'b0, 8'haa);
        ld_dd(7'h05);
        rd_chk(1'b1, CDU_SPACE_CODE);
        host.put(1'b0, 1'b0, 8'h45);
        rd_chk(1'b1, 8'haa);
    endtask

    task automatic t_shift();
        host.put(1'b0, 1'b0, 8'h05);
        ld_dd(7'h20);
        host.put(1'b1, 1'b0, 8'h41);
        settle();
        chk({disp_r.cursor_addr_counter, disp_r.shift_ofs}, {7'h1f, 7'h7f});
        rd_chk(1'b1, CDU_SPACE_CODE);
        chk({disp_r.cursor_addr_counter, disp_r.shift_ofs}, {7'h1e, 7'h7f});
        host.put(1'b0, 1'b0, 8'h07);
        host.put(1'b1, 1'b0, 8'h42);
        settle();
        chk({disp_r.cursor_addr_counter, disp_r.shift_ofs}, {7'h1f, 7'h00});
        host.put(1'b0, 1'b0, 8'h42);
        host.put(1'b1, 1'b0, 8'h01);
        settle();
        chk({disp_r.cursor_addr_counter, disp_r.shift_ofs}, {7'h03, 7'h00});
        host.put(1'b0, 1'b0, 8'h06);
        settle();
        chk({disp_r.incr, disp_r.shift_en}, 2'h2);
    endtask

    task automatic t_regs();
        logic [31:0] q;
        reg_acc(1'b1, CDU_REG_CFG, 32'h1, q);
        chk(port_mode_r, CDU_PORT_I80);
        reg_acc(1'b1, CDU_REG_CFG, 32'h3, q);
        chk(port_mode_r, CDU_PORT_I80);
        reg_acc(1'b0, CDU_REG_CFG, 32'h0, q);
        chk(q, 32'h1);
        reg_acc(1'b0, 4'h8, 32'h0, q);
        chk(q, 32'h0);
        reg_acc(1'b0, CDU_REG_STAT, 32'h0, q);
        chk(q, 32'h0019_4003);
        reg_acc(1'b1, CDU_REG_CFG, {30'h0, CDU_PORT_SERIAL}, q);
        chk(port_mode_r, CDU_PORT_SERIAL);
        reg_acc(1'b1, CDU_REG_CFG, {30'h0, CDU_PORT_M68}, q);
        chk(port_mode_r, CDU_PORT_M68);
        clk_en <= 1'b0;
        reg_acc(1'b1, CDU_REG_CFG, 32'h1, q);
        clk_en <= 1'b1;
        chk(port_mode_r, CDU_PORT_M68);
    endtask

    initial
    begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        t_reset();
        t_func();
        t_nibble();
        t_ram();
        t_shift();
        t_regs();
        test_done();
    end

    // the whole run needs well under a thousand cycles
    initial
    begin
        #100000;
        n_mismatch++;
        test_done();
    end
endmodule

bind cdu_instr_unit cdu_instr_unit_checker #(.DD_DEPTH(DD_DEPTH), .CG_DEPTH(CG_DEPTH)) u_chk (
    .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .xfer_stb(xfer_stb), .xfer(xfer),
    .rd_byte_r(rd_byte_r), .rd_valid_r(rd_valid_r), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .disp_r(disp_r), .luma_pct_r(luma_pct_r),
    .port_mode_r(port_mode_r));

// >>> cdu_pkg.sv
/*
 * cdu_pkg: constants, types and field positions for the character display
 * instruction unit.
 * Assumes one 100 MHz core clock; every user of these names imports the package.
 */
package cdu_pkg;

    // sizes
    localparam int CDU_AC_W     = 7;
    localparam int CDU_CG_AW    = 6;
    localparam int CDU_DD_DEPTH = 128;
    localparam int CDU_CG_DEPTH = 64;

    // leading-one positions of instruction bytes
    localparam int CDU_LEAD_DD    = 7;
    localparam int CDU_LEAD_CG    = 6;
    localparam int CDU_LEAD_FUNC  = 5;
    localparam int CDU_LEAD_SHIFT = 4;
    localparam int CDU_LEAD_DISP  = 3;
    localparam int CDU_LEAD_ENTRY = 2;
    localparam int CDU_LEAD_HOME  = 1;
    localparam int CDU_LEAD_CLEAR = 0;

    // field positions inside instruction bytes
    localparam int CDU_FS_WIDTH   = 4;
    localparam int CDU_FS_LINES   = 3;
    localparam int CDU_FS_LUMA_HI = 1;
    localparam int CDU_FS_LUMA_LO = 0;
    localparam int CDU_EM_INCR    = 1;
    localparam int CDU_EM_SHIFT   = 0;
    localparam int CDU_DC_DISP    = 2;
    localparam int CDU_DC_CURSOR  = 1;
    localparam int CDU_DC_BLINK   = 0;
    localparam int CDU_SH_DISP    = 3;
    localparam int CDU_SH_RIGHT   = 2;

    // reset and fill values
    localparam logic [7:0]          CDU_SPACE_CODE = 8'h20;
    localparam logic [CDU_AC_W-1:0] CDU_AC_RESET   = 7'h00;
    localparam logic [7:0]          CDU_CG_RESET   = 8'h00;
    localparam logic                CDU_BUSY_VALUE = 1'b0;

    // luminance in percent
    localparam logic [6:0] CDU_LUMA_100 = 7'h64;
    localparam logic [6:0] CDU_LUMA_75  = 7'h4b;
    localparam logic [6:0] CDU_LUMA_50  = 7'h32;
    localparam logic [6:0] CDU_LUMA_25  = 7'h19;

    // host port modes
    localparam logic [1:0] CDU_PORT_SERIAL = 2'h0;
    localparam logic [1:0] CDU_PORT_I80    = 2'h1;
    localparam logic [1:0] CDU_PORT_M68    = 2'h2;

    // register port
    localparam int         CDU_RA_W     = 4;
    localparam logic [3:0] CDU_REG_CFG  = 4'h0;
    localparam logic [3:0] CDU_REG_STAT = 4'h4;

    // one host transfer from the port front-end
    typedef struct packed {
        logic       cmd_data_select;
        logic       rnw;
        logic [7:0] parallel_bus;
    } cdu_xfer_s;

    // visible display state
    typedef struct packed {
        logic                disp_on;
        logic                cursor_on;
        logic                blink_on;
        logic                two_lines;
        logic                bus_width_sel;
        logic                luma_sel_hi;
        logic                luma_sel_lo;
        logic                incr;
        logic                shift_en;
        logic                glyph_sel;
        logic [CDU_AC_W-1:0] shift_ofs;
        logic [CDU_AC_W-1:0] cursor_addr_counter;
    } cdu_disp_s;

    typedef enum logic [7:0] {
        CDU_OP_NONE  = 8'b0000_0000,
        CDU_OP_CLEAR = 8'b0000_0001,
        CDU_OP_HOME  = 8'b0000_0010,
        CDU_OP_ENTRY = 8'b0000_0100,
        CDU_OP_DISP  = 8'b0000_1000,
        CDU_OP_SHIFT = 8'b0001_0000,
        CDU_OP_FUNC  = 8'b0010_0000,
        CDU_OP_CG    = 8'b0100_0000,
        CDU_OP_DD    = 8'b1000_0000
    } cdu_op_e;

endpackage
